// [tb/sram_lane_model.sv]
// Behavioural model of the clockless 16-bit static memory.
module sram_lane_model (
	// Memory pins from the host
	input wire logic [sram_host_pkg::ADDR_W-1:0] word_index_in,
	input wire logic sel_n_in,
	input wire logic wr_n_in,
	input wire logic oe_n_in,
	input wire logic low_lane_sel_n_in,
	input wire logic high_lane_sel_n_in,
	input wire logic [15:0] host_data_in,
	input wire logic host_oe_n_in,
	// Resolved data lines and contention flag
	output logic [15:0] bus_out,
	output logic clash_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// --------------------------------------------------------------
	// Storage and decode
	// --------------------------------------------------------------
	logic [15:0] mem [int]; // Sparse, so all 19 address bits count
	logic [15:0] cur;
	logic [15:0] wdat;
	logic [1:0] lane;
	logic rd;
	logic wr;

	// Select gates every other input, so nothing acts while it is high.
	assign lane = {~high_lane_sel_n_in, ~low_lane_sel_n_in};
	assign rd = !sel_n_in && wr_n_in && !oe_n_in && lane != 2'b00;
	assign wr = !sel_n_in && !wr_n_in && lane != 2'b00;
	// Undriven data lines are stored as garbage, not as a lucky value.
	assign wdat = host_oe_n_in ? ~host_data_in : host_data_in;

	// --------------------------------------------------------------
	// Write at the end of the strobe overlap
	// --------------------------------------------------------------
	// Storing at the end catches data that changed inside the pulse.
	// The guard keeps the unknown pins before reset from storing anything.
	always @(negedge wr) begin
		if (sel_n_in === 1'b0) begin
			if (!mem.exists(word_index_in))
				mem[word_index_in] = 16'h5a5a;
			if (lane[0])
				mem[word_index_in][7:0] = wdat[7:0];
			if (lane[1])
				mem[word_index_in][15:8] = wdat[15:8];
		end
	end

	// --------------------------------------------------------------
	// Lane drive; a released lane shows the inverse, as nothing pulls it
	// --------------------------------------------------------------
	always @* begin
		cur = mem.exists(word_index_in) ? mem[word_index_in] : 16'h5a5a;
		for (int i = 0; i < 2; i++) begin
			if (rd && lane[i])
				bus_out[i*8+:8] = cur[i*8+:8];
			else if (!host_oe_n_in)
				bus_out[i*8+:8] = host_data_in[i*8+:8];
			else
				bus_out[i*8+:8] = ~cur[i*8+:8];
		end
	end

	// Two drivers on the lines at once are remembered for the bench.
	initial clash_out = 1'b0;
	always @(rd or host_oe_n_in) begin
		if (rd && !host_oe_n_in)
			clash_out = 1'b1;
	end
endmodule

// [tb/test_sram_host.sv]
// Self-checking bench for the static memory host controller.
module test_sram_host;
	timeunit 1ns;
	timeprecision 100ps;

	// --------------------------------------------------------------
	// Signals
	// --------------------------------------------------------------
	localparam int REC = 4;
	logic ref_clk_in, nrst_in, req_in, write_in, retention_in, pwr_in;
	logic [18:0] addr_in, word_index;
	logic [15:0] wdata_in, rdata_out, dq_out, bus;
	logic [1:0] lane_en_in;
	logic ready_out, done_out, rvalid, recovering_out, clash;
	logic sel_n, wr_n, oe_n, lo_n, hi_n, dq_oe_n;
	logic [15:0] shadow [int];
	logic [15:0] expq [$];
	logic [18:0] at [6];
	int n_errors = 0;
	int n_tests = 0;
	int seed = 46484;
	int lat;
	int n;

	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	sram_host #(.REC_CYCLES(REC)) uut (.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in), .req_in(req_in), .write_in(write_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .lane_en_in(lane_en_in),
		.ready_out(ready_out), .done_out(done_out),
		.rdata_valid_out(rvalid), .rdata_out(rdata_out),
		.retention_in(retention_in), .power_restored_in(pwr_in),
		.recovering_out(recovering_out), .word_index_out(word_index),
		.sel_n_out(sel_n), .wr_n_out(wr_n), .oe_n_out(oe_n),
		.low_lane_sel_n_out(lo_n), .high_lane_sel_n_out(hi_n),
		.shared_data_lines_out(dq_out),
		.shared_data_lines_oe_n_out(dq_oe_n),
		.shared_data_lines_in(bus));

	sram_lane_model mem_model (.word_index_in(word_index),
		.sel_n_in(sel_n), .wr_n_in(wr_n), .oe_n_in(oe_n),
		.low_lane_sel_n_in(lo_n), .high_lane_sel_n_in(hi_n),
		.host_data_in(dq_out), .host_oe_n_in(dq_oe_n),
		.bus_out(bus), .clash_out(clash));

	// --------------------------------------------------------------
	// Comparison, verdict and bus tasks
	// --------------------------------------------------------------
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One request; a read notes its expected word before it starts.
	task automatic access(logic wr, logic [18:0] a, logic [15:0] d,
		logic [1:0] ln);
		logic [15:0] m;
		m = {{8{ln[1]}}, {8{ln[0]}}};
		if (!shadow.exists(a))
			shadow[a] = 16'h0000;
		if (wr)
			shadow[a] = (shadow[a] & ~m) | (d & m);
		else
			expq.push_back(shadow[a] & m);
		@(negedge ref_clk_in);
		for (n = 0; ready_out !== 1'b1; n++) begin
			if (n == 2000) begin
				n_errors++;
				finish_test();
			end
			@(negedge ref_clk_in);
		end
		@(posedge ref_clk_in);
		req_in <= 1'b1;
		write_in <= wr;
		addr_in <= a;
		wdata_in <= d;
		lane_en_in <= ln;
		@(posedge ref_clk_in);
		// Fields are scrambled after the take to prove they were latched.
		req_in <= 1'b0;
		write_in <= 1'($random(seed));
		addr_in <= 19'($random(seed));
		wdata_in <= 16'($random(seed));
		lane_en_in <= 2'($random(seed));
		@(negedge ref_clk_in);
		for (lat = 0; done_out !== 1'b1; lat++) begin
			if (lat == 2000) begin
				n_errors++;
				finish_test();
			end
			@(negedge ref_clk_in);
		end
	endtask

	// --------------------------------------------------------------
	// Output watcher
	// --------------------------------------------------------------
	always @(negedge ref_clk_in) begin
		if (rvalid === 1'b1) begin
			if (expq.size() == 0)
				check("unexpected read", 16'h0001, 16'h0000);
			else
				check("read data", rdata_out, expq.pop_front());
		end
		if (wr_n === 1'b0)
			check("write frame", {13'h0, sel_n, oe_n, dq_oe_n}, 16'h0002);
		if (retention_in === 1'b1 || recovering_out === 1'b1)
			check("deselect", {15'h0, sel_n}, 16'h0001);
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		nrst_in = 1'b0;
		req_in = 1'b0;
		write_in = 1'b0;
		addr_in = 19'h00000;
		wdata_in = 16'h0000;
		lane_en_in = 2'h0;
		retention_in = 1'b0;
		pwr_in = 1'b0;
		repeat (12) @(posedge ref_clk_in);
		nrst_in <= 1'b1;
		// Full words at both ends of the space and at random places.
		at[0] = 19'h00000;
		at[1] = 19'h7ffff;
		for (int i = 2; i < 6; i++)
			at[i] = 19'($random(seed));
		for (int i = 0; i < 6; i++) begin
			access(1'b1, at[i], 16'($random(seed)), 2'h3);
			// Setup, strobe and end cycles; done rises with the deselect.
			check("write latency", lat[15:0],
				16'(sram_host_pkg::WP_CYC + 2));
		end
		$display("test full words done");
		// One lane written, then every non-empty lane pattern read back.
		for (int i = 0; i < 6; i++)
			access(1'b1, at[i], 16'($random(seed)), i[0] ? 2'h2 : 2'h1);
		for (int i = 0; i < 6; i++)
			for (int l = 1; l < 4; l++)
				access(1'b0, at[i], 16'h0000, 2'(l));
		$display("test lanes done");
		// An empty lane request finishes at once and touches nothing.
		access(1'b1, at[0], 16'hffff, 2'h0);
		// Done is registered on the taking edge itself, so no wait is seen.
		check("empty latency", lat[15:0], 16'h0000);
		access(1'b0, at[0], 16'h0000, 2'h3);
		// A request under retention is refused.
		@(posedge ref_clk_in);
		retention_in <= 1'b1;
		req_in <= 1'b1;
		write_in <= 1'b1;
		lane_en_in <= 2'h3;
		n = 0;
		repeat (20) begin
			@(negedge ref_clk_in);
			n = n + int'(done_out === 1'b1);
		end
		check("refused request", n[15:0], 16'h0000);
		@(posedge ref_clk_in);
		req_in <= 1'b0;
		retention_in <= 1'b0;
		$display("test retention done");
		// Supply return: recovery wait, then contents still there.
		@(posedge ref_clk_in);
		pwr_in <= 1'b1;
		@(posedge ref_clk_in);
		pwr_in <= 1'b0;
		n = 0;
		repeat (50) begin
			@(negedge ref_clk_in);
			n = n + int'(recovering_out === 1'b1);
		end
		check("recovery cycles", n[15:0], 16'(REC));
		for (int i = 0; i < 6; i++)
			access(1'b0, at[i], 16'h0000, 2'h3);
		repeat (12) @(posedge ref_clk_in);
		check("bus contention", {15'h0, clash}, 16'h0000);
		check("reads left", 16'(expq.size()), 16'h0000);
		$display("test recovery done");
		finish_test();
	end
endmodule

// [verilog/phase_timer.sv]
// Down counter that times the phases of a memory cycle.
module phase_timer (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Control from the owning state machine
	phase_timer_if.timer tmr
);

	logic [sram_host_pkg::TMR_W-1:0] cnt_q;

	// A load wins over counting so a phase always starts from its full length.
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= '0;
		end else if (tmr.load) begin
			cnt_q <= tmr.value;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// The phase ends in the cycle in which the count reaches zero.
	assign tmr.zero = (cnt_q == '0);

endmodule

// [verilog/phase_timer_if.sv]
// Interface between the controller and its phase timer.
interface phase_timer_if;
	logic load;
	logic [sram_host_pkg::TMR_W-1:0] value;
	logic zero;

	modport owner (output load, output value, input zero);
	modport timer (input load, input value, output zero);
endinterface

// [verilog/sram_host.sv]
// Host controller that runs word and lane accesses on an asynchronous memory.
module sram_host #(
	parameter int unsigned REC_CYCLES = sram_host_pkg::REC_CYC
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// User request port
	input wire logic req_in,
	input wire logic write_in,
	input wire logic [sram_host_pkg::ADDR_W-1:0] addr_in,
	input wire logic [sram_host_pkg::DATA_W-1:0] wdata_in,
	input wire logic [1:0] lane_en_in,
	output logic ready_out,
	output logic done_out,
	output logic rdata_valid_out,
	output logic [sram_host_pkg::DATA_W-1:0] rdata_out,
	// Power management
	input wire logic retention_in,
	input wire logic power_restored_in,
	output logic recovering_out,
	// Memory pins
	output logic [sram_host_pkg::ADDR_W-1:0] word_index_out,
	output logic sel_n_out,
	output logic wr_n_out,
	output logic oe_n_out,
	output logic low_lane_sel_n_out,
	output logic high_lane_sel_n_out,
	output logic [sram_host_pkg::DATA_W-1:0] shared_data_lines_out,
	output logic shared_data_lines_oe_n_out,
	input wire logic [sram_host_pkg::DATA_W-1:0] shared_data_lines_in
);

	// ------------------------------------------------------------------
	// State and phase timer
	// ------------------------------------------------------------------
	sram_host_pkg::state_t state_q;
	sram_host_pkg::state_t state_d;
	logic take;
	logic [1:0] lane_q;
	logic [1:0] lane_now;
	logic [sram_host_pkg::TMR_W-1:0] rec_len;

	phase_timer_if tmr ();

	phase_timer u_timer (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.tmr(tmr)
	);

	assign rec_len = sram_host_pkg::TMR_W'(REC_CYCLES - 1);

	// A request is taken only while idle and not holding retention.
	assign take = req_in && (state_q == sram_host_pkg::ST_IDLE) &&
		!retention_in && !power_restored_in;

	// Lanes for the pin registers: fresh from the user on the taking edge.
	assign lane_now = take ? lane_en_in : lane_q;

	// ------------------------------------------------------------------
	// Next state and phase lengths
	// ------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		tmr.load = 1'b0;
		tmr.value = '0;
		case (state_q)
			sram_host_pkg::ST_IDLE: begin
				if (power_restored_in) begin
					state_d = sram_host_pkg::ST_RECOVER;
					tmr.load = 1'b1;
					tmr.value = rec_len;
				end else if (take && lane_en_in != 2'b00) begin
					if (write_in) begin
						state_d = sram_host_pkg::ST_WR_SETUP;
					end else begin
						state_d = sram_host_pkg::ST_RD;
						tmr.load = 1'b1;
						tmr.value = sram_host_pkg::TMR_W'(
							sram_host_pkg::RD_CYC - 1);
					end
				end
			end
			sram_host_pkg::ST_RECOVER: begin
				if (tmr.zero) begin
					state_d = sram_host_pkg::ST_IDLE;
				end
			end
			sram_host_pkg::ST_RD: begin
				if (tmr.zero) begin
					state_d = sram_host_pkg::ST_TURN;
					tmr.load = 1'b1;
					tmr.value = sram_host_pkg::TMR_W'(
						sram_host_pkg::TURN_CYC - 1);
				end
			end
			sram_host_pkg::ST_TURN: begin
				if (tmr.zero) begin
					state_d = sram_host_pkg::ST_IDLE;
				end
			end
			sram_host_pkg::ST_WR_SETUP: begin
				state_d = sram_host_pkg::ST_WR_PULSE;
				tmr.load = 1'b1;
				tmr.value = sram_host_pkg::TMR_W'(sram_host_pkg::WP_CYC - 1);
			end
			sram_host_pkg::ST_WR_PULSE: begin
				if (tmr.zero) begin
					state_d = sram_host_pkg::ST_WR_END;
				end
			end
			sram_host_pkg::ST_WR_END: begin
				state_d = sram_host_pkg::ST_IDLE;
			end
			default: begin
				state_d = sram_host_pkg::ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= sram_host_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------------
	// Request capture
	// ------------------------------------------------------------------
	// Address, write data and lanes are held for the whole cycle.
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lane_q <= 2'b00;
			word_index_out <= sram_host_pkg::ADDR_RST;
			shared_data_lines_out <= sram_host_pkg::DATA_RST;
		end else if (take) begin
			lane_q <= lane_en_in;
			word_index_out <= addr_in;
			shared_data_lines_out <= wdata_in;
		end
	end

	// ------------------------------------------------------------------
	// Memory control pins
	// ------------------------------------------------------------------
	// Pins follow the next state so that each one comes from a flip-flop
	// and changes on the same edge as the state it belongs to.
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sel_n_out <= 1'b1;
			wr_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			low_lane_sel_n_out <= 1'b1;
			high_lane_sel_n_out <= 1'b1;
			shared_data_lines_oe_n_out <= 1'b1;
		end else begin
			sel_n_out <= 1'b1;
			wr_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			low_lane_sel_n_out <= 1'b1;
			high_lane_sel_n_out <= 1'b1;
			shared_data_lines_oe_n_out <= 1'b1;
			case (state_d)
				sram_host_pkg::ST_RD: begin
					sel_n_out <= 1'b0;
					oe_n_out <= 1'b0;
					low_lane_sel_n_out <= !lane_now[sram_host_pkg::LANE_LO];
					high_lane_sel_n_out <= !lane_now[sram_host_pkg::LANE_HI];
				end
				sram_host_pkg::ST_WR_SETUP,
				sram_host_pkg::ST_WR_END: begin
					// Strobe high at both ends frames the write.
					sel_n_out <= 1'b0;
					low_lane_sel_n_out <= !lane_now[sram_host_pkg::LANE_LO];
					high_lane_sel_n_out <= !lane_now[sram_host_pkg::LANE_HI];
					shared_data_lines_oe_n_out <= 1'b0;
				end
				sram_host_pkg::ST_WR_PULSE: begin
					sel_n_out <= 1'b0;
					wr_n_out <= 1'b0;
					low_lane_sel_n_out <= !lane_now[sram_host_pkg::LANE_LO];
					high_lane_sel_n_out <= !lane_now[sram_host_pkg::LANE_HI];
					shared_data_lines_oe_n_out <= 1'b0;
				end
				default: begin
					// Idle, recovery and turnaround keep the part deselected.
					sel_n_out <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// User answers
	// ------------------------------------------------------------------
	// Unselected lanes read back as zero since the part leaves them floating.
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= sram_host_pkg::DATA_RST;
			rdata_valid_out <= 1'b0;
		end else begin
			rdata_valid_out <= 1'b0;
			if (state_q == sram_host_pkg::ST_RD && tmr.zero) begin
				rdata_valid_out <= 1'b1;
				rdata_out <= {
					lane_q[sram_host_pkg::LANE_HI] ?
						shared_data_lines_in[15:8] : 8'h00,
					lane_q[sram_host_pkg::LANE_LO] ?
						shared_data_lines_in[7:0] : 8'h00
				};
			end
		end
	end

	// Done marks the end of a write, a read, or an empty-lane request.
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			done_out <= 1'b0;
		end else begin
			done_out <= (state_q == sram_host_pkg::ST_WR_END) ||
				(state_q == sram_host_pkg::ST_RD && tmr.zero) ||
				(take && lane_en_in == 2'b00);
		end
	end

	// Ready and recovery status.
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ready_out <= 1'b0;
			recovering_out <= 1'b0;
		end else begin
			ready_out <= (state_d == sram_host_pkg::ST_IDLE) && !take;
			recovering_out <= (state_d == sram_host_pkg::ST_RECOVER);
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_no_contention;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		!(!shared_data_lines_oe_n_out && !oe_n_out);
	endproperty
	a_no_contention: assert property (p_no_contention)
		else $error("Host drives data while the memory output is on.");

	property p_turnaround;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		$rose(oe_n_out) |-> shared_data_lines_oe_n_out[*2];
	endproperty
	a_turnaround: assert property (p_turnaround)
		else $error("Data driven too soon after the output gate closed.");

	property p_write_start;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		$fell(wr_n_out) |-> !sel_n_out && !shared_data_lines_oe_n_out &&
			!(low_lane_sel_n_out && high_lane_sel_n_out) &&
			$past(!sel_n_out);
	endproperty
	a_write_start: assert property (p_write_start)
		else $error("Write strobe fell without select, lane and data set.");

	property p_write_width;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		$fell(wr_n_out) |-> (!wr_n_out)[*4] ##1 wr_n_out;
	endproperty
	a_write_width: assert property (p_write_width)
		else $error("Write strobe low for other than four cycles.");

	property p_write_end;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		$rose(wr_n_out) |-> !sel_n_out && !shared_data_lines_oe_n_out
			##1 sel_n_out;
	endproperty
	a_write_end: assert property (p_write_end)
		else $error("Write end not framed by the strobe with data held.");

	property p_recovery_idle;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(state_q == sram_host_pkg::ST_IDLE && power_restored_in)
			|=> (sel_n_out && recovering_out)[*3];
	endproperty
	a_recovery_idle: assert property (p_recovery_idle)
		else $error("Memory selected during recovery time.");

	property p_read_hold;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		$fell(oe_n_out) |-> (!oe_n_out && wr_n_out)[*6] ##1 oe_n_out;
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("Read access not held for six cycles.");

endmodule

// [verilog/sram_host_pkg.sv]
// Constants, timing and state encoding for the static memory host controller.
// Operation
// - Write starts only when select, strobe and a lane are active.
// - Write ends as soon as select, strobe or lanes go inactive.
// - Controller never drives data while the memory drives the bus.
// - After retention supply returns, wait recovery time before access.
package sram_host_pkg;

	// ------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W = 19;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned WORDS = 524288;
	localparam int unsigned LANE_LO = 0;
	localparam int unsigned LANE_HI = 1;

	// ------------------------------------------------------------------
	// Timing, in nanoseconds (recovery in milliseconds) and in cycles of the 100 MHz clock
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned T_ACCESS_NS = 55;
	localparam int unsigned T_WP_NS = 40;
	localparam int unsigned T_OHZ_NS = 20;
	localparam int unsigned T_REC_MS = 5;
	localparam int unsigned RD_CYC =
		(T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WP_CYC =
		(T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TURN_CYC =
		(T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned REC_CYC =
		(T_REC_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMR_W = 20;

	// ------------------------------------------------------------------
	// Reset values of the pin registers
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	// ------------------------------------------------------------------
	// Controller states
	// ------------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_RECOVER = 8'h02,
		ST_RD = 8'h04,
		ST_TURN = 8'h08,
		ST_WR_SETUP = 8'h10,
		ST_WR_PULSE = 8'h20,
		ST_WR_END = 8'h40
	} state_t;

endpackage
